// ===== include/swc_pkg.sv
// Constants, types and register map of the sleep and wake controller.
// Assumes a single system clock that keeps running while the core sleeps.
package swc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Clock and timing
   localparam int CLK_NS       = 4;                              // System clock period
   localparam int TOSC_NS      = 50;                             // Shortest oscillator period
   localparam int TOSC_CYC     = (TOSC_NS + CLK_NS - 1) / CLK_NS; // Cycles per period, rounded up
   localparam int OST_PERIODS  = 1024;                           // Start-up wait in periods
   localparam logic [15:0] VECTOR_ADDR = 16'h0004;               // Interrupt vector

   ////////////////////////////////////////////////////////////////////////////
   // Oscillator modes
   localparam logic [1:0] LOW_POWER_OSC_MODE  = 2'h0;
   localparam logic [1:0] CRYSTAL_OSC_MODE    = 2'h1;
   localparam logic [1:0] HIGH_SPEED_OSC_MODE = 2'h2;
   localparam logic [1:0] RC_OSC_MODE         = 2'h3;

   ////////////////////////////////////////////////////////////////////////////
   // Register map
   localparam logic [3:0] REG_STATUS = 4'h0;  // Sticky events, write one to clear
   localparam logic [3:0] REG_MASK   = 4'h4;  // Interrupt mask, same layout
   localparam logic [3:0] REG_STATE  = 4'h8;  // Read-only live state
   localparam logic [7:0] MASK_RST   = 8'h00; // Mask after reset
   // Event bit positions
   localparam int EV_SLEEP = 0;               // Sleep entered
   localparam int EV_WIRQ  = 1;               // Woken by interrupt
   localparam int EV_WWDT  = 2;               // Woken by watchdog
   localparam int EV_WRST  = 3;               // Watchdog reset while awake
   localparam int EV_PINRST = 4;              // Master clear pin reset
   localparam int EV_N     = 5;               // Number of events

   ////////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [1:0] {
      SWC_RUN, SWC_SLEEP, SWC_OST, SWC_RESUME
   } swc_state_e;

   typedef struct packed {
      logic ext_en;      // External pin interrupt enable
      logic ext_flag;    // External pin interrupt flag
      logic chg_en;      // Port change interrupt enable
      logic chg_flag;    // Port change interrupt flag
   } swc_irq_s;

   typedef struct packed {
      logic [7:0] out;   // Output latch levels
      logic [7:0] oe;    // Output enables, high while driven
   } swc_io_s;

endpackage

// ===== rtl/swc_top.sv
// Sleep and wake controller: sleep entry, wake-up paths, start-up wait.
// Assumes all inputs synchronous to clk_sys, which never stops.
`timescale 1ns/1ps
`default_nettype none

module swc_top
   import swc_pkg::*;
#(
   parameter int OST_COUNT = OST_PERIODS  // Start-up wait in periods
) (
   input  wire logic        clk_sys,
   input  wire logic        reset,
   input  wire logic        sleep_exec,
   input  wire logic        clrwdt_exec,
   input  wire logic [15:0] pc,
   input  wire logic        global_irq_enable,
   input  wire swc_irq_s    irq_src,
   input  wire logic        wdt_enable,
   input  wire logic        wdt_expire,
   input  wire logic        master_clear_pin_n,
   input  wire logic [1:0]  osc_mode,
   input  wire swc_io_s     io_core,
   output var  swc_io_s     io_pin,
   output logic             osc_driver_en,
   output logic             core_hold,
   output logic             core_reset,
   output logic             wdt_clear,
   output logic             power_down_flag,
   output logic             timeout_flag,
   output logic             prefetch_req,
   output logic [15:0]      prefetch_addr,
   output logic             vector_req,
   output logic [15:0]      vector_addr,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [7:0]       reg_rdata,
   output logic             irq
);

   ////////////////////////////////////////////////////////////////////////////
   // State
   swc_state_e  state_r, state_nxt;         // Sequencer state
   logic        vec_pend_r, vec_pend_nxt;   // Vector after resume
   logic [10:0] ost_r, ost_nxt;             // Periods waited
   logic [4:0]  div_r, div_nxt;             // Period divider
   logic        osc_r, osc_nxt;             // Oscillator driver on
   logic        hold_r, hold_nxt;           // Core stalled
   logic        crst_r, crst_nxt;           // Internal core reset
   logic        wclr_r, wclr_nxt;           // Watchdog clear pulse
   logic        pwrdn_r, pwrdn_nxt;         // Power-down flag
   logic        to_r, to_nxt;               // Time-out flag
   logic        pf_r, pf_nxt;               // Prefetch request
   logic [15:0] pfa_r, pfa_nxt;             // Prefetch address
   logic        vec_r, vec_nxt;             // Vector request
   swc_io_s     io_r, io_nxt;               // Pin drive state
   logic [EV_N-1:0] ev;                     // Events this cycle
   logic        irq_pend;                   // Enabled source flagged
   logic        pin_rst;                    // Pin reset active
   logic        tick;                       // One oscillator period

   // Enabled sources only; the global enable plays no part here
   assign irq_pend = (irq_src.ext_en & irq_src.ext_flag)
                   | (irq_src.chg_en & irq_src.chg_flag);
   assign pin_rst = ~master_clear_pin_n;
   assign tick = (div_r == 5'(TOSC_CYC - 1));

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer next values
   always_comb begin
      state_nxt    = state_r;
      vec_pend_nxt = vec_pend_r;
      ost_nxt      = ost_r;
      div_nxt      = tick ? 5'h00 : div_r + 5'h01;
      osc_nxt      = osc_r;
      hold_nxt     = hold_r;
      crst_nxt     = 1'b0;
      wclr_nxt     = 1'b0;
      pwrdn_nxt    = pwrdn_r;
      to_nxt       = to_r;
      pf_nxt       = 1'b0;
      pfa_nxt      = pfa_r;
      vec_nxt      = 1'b0;
      io_nxt       = io_r;
      ev           = '0;
      if (pin_rst) begin
         // Pin reset always restarts the sequencer and resets the core; the flags and the mask keep their values, status records the pin event
         state_nxt    = SWC_RUN;
         crst_nxt     = 1'b1;
         osc_nxt      = 1'b1;
         hold_nxt     = 1'b0;
         vec_pend_nxt = 1'b0;
         io_nxt       = io_core;
         ev[EV_PINRST] = 1'b1;
      end else begin
         unique case (state_r)
            SWC_RUN: begin
               // Track the core drive state while awake
               io_nxt = io_core;
               if (clrwdt_exec) begin
                  wclr_nxt = 1'b1;
                  pwrdn_nxt = 1'b1;
                  to_nxt   = 1'b1;
               end
               if (wdt_enable && wdt_expire) begin
                  // Internal reset only; the pin is never driven
                  crst_nxt    = 1'b1;
                  to_nxt      = 1'b0;
                  ev[EV_WRST] = 1'b1;
               end else if (sleep_exec) begin
                  // Only the sleep instruction gets here
                  wclr_nxt     = 1'b1;
                  pwrdn_nxt    = 1'b0;
                  to_nxt       = 1'b1;
                  pf_nxt       = 1'b1;
                  pfa_nxt      = pc + 16'h0001;
                  hold_nxt     = 1'b1;
                  io_nxt       = io_core;
                  ev[EV_SLEEP] = 1'b1;
                  vec_pend_nxt = global_irq_enable;
                  if (irq_pend) begin
                     // Already pending: wake right after entry
                     state_nxt   = SWC_RESUME;
                     ev[EV_WIRQ] = 1'b1;
                  end else begin
                     state_nxt = SWC_SLEEP;
                     osc_nxt   = 1'b0;
                  end
               end
            end
            SWC_SLEEP: begin
               // Pins keep their frozen value
               vec_pend_nxt = global_irq_enable;
               if ((wdt_enable && wdt_expire) || irq_pend) begin
                  wclr_nxt  = 1'b1;
                  osc_nxt   = 1'b1;
                  ost_nxt   = 11'h000;
                  div_nxt   = 5'h00;
                  state_nxt = (osc_mode == RC_OSC_MODE) ?
                              SWC_RESUME : SWC_OST;
                  if (wdt_enable && wdt_expire) begin
                     // Watchdog wake resumes with time-out low
                     to_nxt       = 1'b0;
                     vec_pend_nxt = 1'b0;
                     ev[EV_WWDT]  = 1'b1;
                  end else begin
                     ev[EV_WIRQ] = 1'b1;
                  end
               end
            end
            SWC_OST: begin
               // Wait for the oscillator to settle
               if (tick) begin
                  ost_nxt = ost_r + 11'h001;
                  if (ost_r == 11'(OST_COUNT - 1)) begin
                     state_nxt = SWC_RESUME;
                  end
               end
            end
            SWC_RESUME: begin
               // Release the core; vector after the next instruction
               hold_nxt     = 1'b0;
               vec_nxt      = vec_pend_r;
               vec_pend_nxt = 1'b0;
               state_nxt    = SWC_RUN;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer registers
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_r    <= SWC_RUN;
         vec_pend_r <= 1'b0;
         ost_r      <= 11'h000;
         div_r      <= 5'h00;
         osc_r      <= 1'b1;
         hold_r     <= 1'b0;
         crst_r     <= 1'b0;
         wclr_r     <= 1'b0;
         pwrdn_r    <= 1'b1;   // Set at power-up
         to_r       <= 1'b1;
         pf_r       <= 1'b0;
         pfa_r      <= 16'h0000;
         vec_r      <= 1'b0;
         io_r       <= '0;
      end else begin
         state_r    <= state_nxt;
         vec_pend_r <= vec_pend_nxt;
         ost_r      <= ost_nxt;
         div_r      <= div_nxt;
         osc_r      <= osc_nxt;
         hold_r     <= hold_nxt;
         crst_r     <= crst_nxt;
         wclr_r     <= wclr_nxt;
         pwrdn_r    <= pwrdn_nxt;
         to_r       <= to_nxt;
         pf_r       <= pf_nxt;
         pfa_r      <= pfa_nxt;
         vec_r      <= vec_nxt;
         io_r       <= io_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register file next values
   logic [EV_N-1:0] sts_r, sts_nxt;    // Sticky events
   logic [EV_N-1:0] msk_r, msk_nxt;    // Interrupt mask
   logic [7:0]      rd_r, rd_nxt;      // Read data
   logic            irq_r, irq_nxt;    // Interrupt line

   always_comb begin
      sts_nxt = sts_r;
      msk_nxt = msk_r;
      rd_nxt  = 8'h00;
      if (reg_wr && reg_addr == REG_STATUS) begin
         sts_nxt = sts_r & ~reg_wdata[EV_N-1:0];
      end
      if (reg_wr && reg_addr == REG_MASK) begin
         msk_nxt = reg_wdata[EV_N-1:0];
      end
      // New events win over a clear in the same cycle
      sts_nxt = sts_nxt | ev;
      if (reg_rd) begin
         unique case (reg_addr)
            REG_STATUS: rd_nxt = {3'h0, sts_r};
            REG_MASK:   rd_nxt = {3'h0, msk_r};
            REG_STATE:  rd_nxt = {3'h0, to_r, pwrdn_r, osc_r, state_r};
            default:    rd_nxt = 8'h00;
         endcase
      end
      irq_nxt = |(sts_nxt & msk_nxt);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register file registers
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sts_r <= '0;
         msk_r <= MASK_RST[EV_N-1:0];
         rd_r  <= 8'h00;
         irq_r <= 1'b0;
      end else begin
         sts_r <= sts_nxt;
         msk_r <= msk_nxt;
         rd_r  <= rd_nxt;
         irq_r <= irq_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign io_pin          = io_r;
   assign osc_driver_en   = osc_r;
   assign core_hold       = hold_r;
   assign core_reset      = crst_r;
   assign wdt_clear       = wclr_r;
   assign power_down_flag = pwrdn_r;
   assign timeout_flag    = to_r;
   assign prefetch_req    = pf_r;
   assign prefetch_addr   = pfa_r;
   assign vector_req      = vec_r;
   assign vector_addr     = VECTOR_ADDR;
   assign reg_rdata       = rd_r;
   assign irq             = irq_r;

endmodule

`default_nettype wire

// ===== verif/swc_sva.sv
// Checker for the sleep and wake controller ports.
// Assumes a bind onto swc_top, one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module swc_sva
   import swc_pkg::*;
#(
   parameter int OST_COUNT = OST_PERIODS  // Start-up wait in periods
) (
   input wire logic        clk_sys,
   input wire logic        reset,
   input wire logic        sleep_exec,
   input wire logic [15:0] pc,
   input wire logic        wdt_enable,
   input wire logic        wdt_expire,
   input wire logic        master_clear_pin_n,
   input wire logic [1:0]  osc_mode,
   input wire swc_io_s     io_pin,
   input wire logic        osc_driver_en,
   input wire logic        core_hold,
   input wire logic        core_reset,
   input wire logic        wdt_clear,
   input wire logic        power_down_flag,
   input wire logic        timeout_flag,
   input wire logic        prefetch_req,
   input wire logic [15:0] prefetch_addr,
   input wire logic        vector_req,
   input wire logic [15:0] vector_addr
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////////////
   // Sleep instruction taken while running
   sequence s_enter;
      sleep_exec && !core_hold && !core_reset && master_clear_pin_n && !wdt_expire;
   endsequence
   // Oscillator restart that no pin reset caused
   sequence s_wake;
      $rose(osc_driver_en) && master_clear_pin_n && $past(master_clear_pin_n);
   endsequence
   ////////////////////////////////////////////////////////////////////////////
   sleep_entry_a: assert property (s_enter |=> wdt_clear && prefetch_req && core_hold
      && !power_down_flag && timeout_flag) else $error("sleep entry outputs wrong");
   prefetch_pc_a: assert property (s_enter |=> prefetch_addr == $past(pc) + 16'h0001)
      else $error("prefetch address wrong");
   sleep_cause_a: assert property ($fell(osc_driver_en) |-> $past(sleep_exec))
      else $error("oscillator stopped without sleep");
   io_freeze_a: assert property (!osc_driver_en && !$past(osc_driver_en) |-> $stable(io_pin))
      else $error("port state moved while asleep");
   pin_reset_a: assert property (!master_clear_pin_n |=> core_reset)
      else $error("pin reset not applied");
   wdt_reset_a: assert property (wdt_expire && wdt_enable && !core_hold && master_clear_pin_n
      |=> core_reset) else $error("awake expiry did not reset");
   wake_clear_a: assert property (s_wake |-> wdt_clear)
      else $error("wake without watchdog clear");
   ost_wait_a: assert property (s_wake ##0 osc_mode != RC_OSC_MODE |=> core_hold [*8])
      else $error("start-up wait too short");
   rc_nowait_a: assert property (s_wake ##0 osc_mode == RC_OSC_MODE |=> !core_hold)
      else $error("wait seen in RC mode");
   vector_addr_a: assert property (vector_req |-> vector_addr == VECTOR_ADDR && $past(core_hold))
      else $error("vector request wrong");
endmodule
bind swc_top swc_sva #(.OST_COUNT(OST_COUNT)) u_sva (.clk_sys, .reset, .sleep_exec, .pc, .wdt_enable,
   .wdt_expire, .master_clear_pin_n, .osc_mode, .io_pin, .osc_driver_en, .core_hold, .core_reset,
   .wdt_clear, .power_down_flag, .timeout_flag, .prefetch_req, .prefetch_addr, .vector_req, .vector_addr);
`default_nettype wire

// ===== verif/swc_wdt_model.sv
// Watchdog model on the far side of the controller.
// Assumes it is clocked with clk_sys; it runs on through sleep.
`timescale 1ns/1ps
`default_nettype none
module swc_wdt_model #(
   parameter int PERIOD = 40  // Cycles from clear to expiry
) (
   input  wire logic clk_sys,
   input  wire logic enable,
   input  wire logic clear,
   output logic      expire
);
   int count_r = 0;  // Cycles since the last clear
   initial expire = 1'b0;
   // Counts while enabled, asleep too; a clear restarts it
   always @(posedge clk_sys) begin
      if (clear || !enable || count_r == PERIOD - 1) count_r <= 0;
      else count_r <= count_r + 1;
      expire <= enable && !clear && count_r == PERIOD - 1;
   end
endmodule
`default_nettype wire

// ===== verif/testbench.sv
// Self-checking bench of the sleep and wake controller.
// Assumes swc_top, the watchdog model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module testbench
   import swc_pkg::*;
;
   logic        clk_sys = 0, reset = 1, sleep_exec = 0, clrwdt_exec = 0, global_irq_enable = 0;
   logic        wdt_enable = 0, master_clear_pin_n = 1, reg_wr = 0, reg_rd = 0;
   logic [15:0] pc = 0;
   logic [1:0]  osc_mode = RC_OSC_MODE;
   logic [3:0]  reg_addr = 0;
   logic [7:0]  reg_wdata = 0;
   swc_irq_s    irq_src = '0;
   swc_io_s     io_core = '0, io_pin, iov;
   logic        osc_driver_en, core_hold, core_reset, wdt_clear, power_down_flag, timeout_flag;
   logic        prefetch_req, vector_req, irq, wdt_expire, g, e, xv, xs, seen_v, seen_r;
   logic [15:0] prefetch_addr, vector_addr;
   logic [7:0]  reg_rdata;
   logic [1:0]  m;
   int          mismatches = 0, n_tests = 0, n;
   // Rows: mode, global enable, pin source, vector expected, wait expected
   logic [5:0]  rows [5] = '{6'h05, 6'h1B, 6'h21, 6'h3E, 6'h30};
   swc_top #(.OST_COUNT(4)) u_dut (.clk_sys, .reset, .sleep_exec, .clrwdt_exec, .pc, .global_irq_enable,
      .irq_src, .wdt_enable, .wdt_expire, .master_clear_pin_n, .osc_mode, .io_core, .io_pin, .osc_driver_en,
      .core_hold, .core_reset, .wdt_clear, .power_down_flag, .timeout_flag, .prefetch_req, .prefetch_addr,
      .vector_req, .vector_addr, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
   swc_wdt_model u_wdt (.clk_sys, .enable(wdt_enable), .clear(wdt_clear), .expire(wdt_expire));
   always #2 clk_sys = ~clk_sys;
   ////////////////////////////////////////////////////////////////////////////
   // Compare and count
   task chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task cyc(input int k);
      repeat (k) @(posedge clk_sys);
   endtask
   // One-cycle register write and read
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys); reg_addr <= a; reg_wdata <= d; reg_wr <= 1;
      @(posedge clk_sys); reg_wr <= 0;
   endtask
   task rdc(input logic [3:0] a, input logic [7:0] exp, input string what);
      @(posedge clk_sys); reg_addr <= a; reg_rd <= 1;
      @(posedge clk_sys); reg_rd <= 0;
      #1 chk(reg_rdata, exp, what);
   endtask
   // Sleep instruction for one cycle, then look at the reply
   task go_sleep(input logic [15:0] a);
      @(posedge clk_sys); pc <= a; sleep_exec <= 1;
      @(posedge clk_sys); sleep_exec <= 0;
      #1;
   endtask
   // Bounded wait for the core to run again
   task wait_wake;
      n = 0; seen_v = 0; seen_r = 0;
      while (core_hold === 1'b1 && n < 200) begin
         @(posedge clk_sys); #1 n++;
         seen_v |= vector_req; seen_r |= core_reset;
      end
   endtask
   task print_verdict;
      $display("tests %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #20000 mismatches++;
      print_verdict;
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      cyc(16); reset <= 0;
      // Ordinary interrupt wake-ups, every mode
      foreach (rows[i]) begin
         {m, g, e, xv, xs} = rows[i];
         iov = {8'hA5 ^ 8'(i), 8'hF0};
         @(posedge clk_sys); osc_mode <= m; global_irq_enable <= g; irq_src <= {e, 1'b0, !e, 1'b0}; io_core <= iov;
         go_sleep(16'h0100 + 16'(i));
         chk(prefetch_addr, 16'h0101 + 16'(i), "prefetch");
         chk({osc_driver_en, power_down_flag, timeout_flag, wdt_clear, core_hold}, 5'b00111, "entry");
         @(posedge clk_sys); io_core <= ~iov;
         cyc(3); #1 chk(io_pin, iov, "io");
         @(posedge clk_sys); irq_src <= {e, e, !e, !e};
         wait_wake;
         chk({core_hold, n > 20, seen_v, timeout_flag}, {1'b0, xs, xv, 1'b1}, "wake");
         rdc(REG_STATUS, 8'h03, "status");
         wr(REG_STATUS, 8'h1F); irq_src <= '0;
      end
      // Flags without enables must not wake; mask, clear, pin reset
      @(posedge clk_sys); irq_src <= 4'b0101;
      go_sleep(16'h0200);
      cyc(20); #1 chk(osc_driver_en, 0, "no wake");
      rdc(REG_STATUS, 8'h01, "sleep event");
      wr(REG_MASK, 8'h01); cyc(2); #1 chk(irq, 1, "irq on");
      wr(REG_STATUS, 8'h01); cyc(2); #1 chk(irq, 0, "irq off");
      rdc(4'hC, 8'h00, "unmapped");
      @(posedge clk_sys); master_clear_pin_n <= 0;
      cyc(3); #1 chk({core_reset, osc_driver_en, power_down_flag}, 3'b110, "pin reset");
      @(posedge clk_sys); master_clear_pin_n <= 1;
      cyc(3); #1 chk({core_reset, core_hold}, 0, "pin release");
      rdc(REG_STATUS, 8'h10, "pin event");
      wr(REG_STATUS, 8'h1F); irq_src <= 4'b1100;
      // Enabled flag already pending: immediate wake
      go_sleep(16'h0300);
      chk(osc_driver_en, 1, "stay on");
      wait_wake;
      chk({core_hold, seen_v}, 0, "immediate");
      @(posedge clk_sys); irq_src <= '0; wdt_enable <= 1;
      // Watchdog: wake while asleep, reset while awake
      go_sleep(16'h0400);
      wait_wake;
      chk({core_hold, timeout_flag, seen_r}, 0, "wdt wake");
      // Watchdog-clear instruction sets both flags and clears the counter
      @(posedge clk_sys); clrwdt_exec <= 1;
      @(posedge clk_sys); clrwdt_exec <= 0;
      #1 chk({wdt_clear, power_down_flag, timeout_flag}, 3'b111, "clear watchdog");
      n = 0;
      while (core_reset !== 1'b1 && n < 100) begin
         @(posedge clk_sys); #1 n++;
      end
      chk(core_reset, 1, "wdt reset");
      @(posedge clk_sys); wdt_enable <= 0; reset <= 1;
      // Second reset in mid-run
      cyc(2); reset <= 0;
      #1 chk({osc_driver_en, power_down_flag, timeout_flag, core_hold, irq}, 5'b11100, "reset");
      rdc(REG_MASK, MASK_RST, "mask reset");
      print_verdict;
   end
endmodule
`default_nettype wire
